/* File: cad_pkg.sv */
package cad_pkg;

    // register page that holds every byte of this block
    localparam logic [3:0]  CAD_PAGE          = 4'h0;

    // counter byte addresses
    localparam logic [7:0]  CAD_COUNT_LOW     = 8'hf9;
    localparam logic [7:0]  CAD_COUNT_HIGH    = 8'hfa;

    // per-module byte addresses, module 0 in the lowest byte
    localparam int          CAD_MODULES       = 6;
    localparam logic [47:0] CAD_CMP_LOW_ADDR  = {8'hd2, 8'hfd, 8'hed, 8'heb, 8'he9, 8'hfb};
    localparam logic [47:0] CAD_CMP_HIGH_ADDR = {8'hd3, 8'hfe, 8'hee, 8'hec, 8'hea, 8'hfc};

    // module that becomes the watchdog while the watchdog is on
    localparam int          CAD_WD_MODULE     = 5;

    // reset values
    localparam logic [15:0] CAD_COUNT_RST     = 16'h0000;
    localparam logic [7:0]  CAD_SNAP_RST      = 8'h00;
    localparam logic [15:0] CAD_CMP_RST       = 16'h0000;
    localparam logic [15:0] CAD_RELOAD_RST    = 16'h0000;
    localparam logic        CAD_CMP_EN_RST    = 1'b0;
    localparam logic [7:0]  CAD_RDATA_RST     = 8'h00;
    localparam logic [7:0]  CAD_UNMAPPED_READ = 8'h00;

    // bus read cycle: selected byte, or nothing
    typedef enum logic [1:0] {
        CAD_SEL_NONE  = 2'b00,
        CAD_SEL_COUNT = 2'b01,
        CAD_SEL_CMP   = 2'b10
    } cad_sel_t;

endpackage : cad_pkg

/* File: cad_counter.sv */
`timescale 1ns/1ps
module cad_counter
    import cad_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        tick,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic        rd_low,
    input  wire logic [7:0]  wdata,
    input  wire logic        wd_lock,
    output logic      [15:0] count_q,
    output logic      [7:0]  snap_q
);

    typedef struct packed {
        logic [15:0] count;
        logic [7:0]  snap;
    } cad_cnt_state_t;

    cad_cnt_state_t st_r;
    cad_cnt_state_t st_nxt;

    // a software write replaces the tick in that cycle, so a byte just written is not bumped
    always_comb begin
        st_nxt = st_r;
        if (wr_low && !wd_lock) begin
            st_nxt.count[7:0] = wdata;
        end else if (wr_high && !wd_lock) begin
            st_nxt.count[15:8] = wdata;
        end else if (tick) begin
            st_nxt.count = st_r.count + 16'h0001;
        end
        // freeze the upper byte the moment the lower one is read
        if (rd_low) begin
            st_nxt.snap = st_r.count[15:8];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.count <= CAD_COUNT_RST;
            st_r.snap  <= CAD_SNAP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count_q = st_r.count;
    assign snap_q  = st_r.snap;

endmodule : cad_counter

/* File: cad_channel.sv */
`timescale 1ns/1ps
module cad_channel
    import cad_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wr_low,
    input  wire logic        wr_high,
    input  wire logic [7:0]  wdata,
    input  wire logic        reload_sel,
    input  wire logic        mode_lock,
    input  wire logic        mode_wr,
    input  wire logic        mode_cmp_en,
    output logic      [15:0] compare_q,
    output logic      [15:0] reload_q,
    output logic             cmp_en_q
);

    typedef struct packed {
        logic [15:0] compare;
        logic [15:0] reload;
        logic        cmp_en;
    } cad_ch_state_t;

    cad_ch_state_t st_r;
    cad_ch_state_t st_nxt;

    // byte writes come after the mode write so their side effect wins a same-cycle clash
    always_comb begin
        st_nxt = st_r;
        if (mode_wr && !mode_lock) begin
            st_nxt.cmp_en = mode_cmp_en;
        end
        if (wr_low) begin
            if (reload_sel) begin
                st_nxt.reload[7:0] = wdata;
            end else begin
                st_nxt.compare[7:0] = wdata;
            end
            if (!mode_lock) begin
                st_nxt.cmp_en = 1'b0;
            end
        end
        if (wr_high) begin
            if (reload_sel) begin
                st_nxt.reload[15:8] = wdata;
            end else begin
                st_nxt.compare[15:8] = wdata;
            end
            if (!mode_lock) begin
                st_nxt.cmp_en = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.compare <= CAD_CMP_RST;
            st_r.reload  <= CAD_RELOAD_RST;
            st_r.cmp_en  <= CAD_CMP_EN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign compare_q = st_r.compare;
    assign reload_q  = st_r.reload;
    assign cmp_en_q  = st_r.cmp_en;

endmodule : cad_channel

/* File: cad_counter_array.sv */
// Operation
// - counter low byte at 0xf9 is read/write and resets to zero.
// - high byte reads a snapshot loaded only when the low byte is read.
// - low byte ignores software writes while the watchdog is enabled.
// - high byte ignores software writes while the watchdog is enabled.
// - each module has a read/write compare low byte at its own address.
// - each module has a read/write compare high byte at its own address.
// - low address reaches the reload low byte when reload select is set.
// - high address reaches the reload high byte when reload select is set.
// - writing a module low byte clears its comparator enable.
// - writing a module high byte sets its comparator enable.
// - all these bytes sit on register page zero.
// - comparator enable at one turns on that module's comparator.
// - while the watchdog runs, module five's mode cannot change.
`timescale 1ns/1ps
module cad_counter_array
    import cad_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic [3:0]  SFR_PAGE,
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic [7:0]  SFR_WDATA,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    output logic      [7:0]  SFR_RDATA,
    output logic             SFR_HIT,
    input  wire logic        COUNT_TICK,
    input  wire logic        WATCHDOG_ENABLE,
    input  wire logic        RELOAD_SELECT,
    input  wire logic [5:0]  MODE_WR,
    input  wire logic [5:0]  MODE_COMPARATOR_ENABLE,
    output logic      [15:0] COUNTER_VALUE,
    output logic      [95:0] COMPARE_VALUE,
    output logic      [95:0] RELOAD_VALUE,
    output logic      [5:0]  COMPARATOR_ENABLE
);

    typedef struct packed {
        logic [7:0] rdata;
        logic       hit;
    } cad_top_state_t;

    cad_top_state_t st_r;
    cad_top_state_t st_nxt;

    logic        page_ok;
    logic        cnt_low_sel;
    logic        cnt_high_sel;
    logic [5:0]  cmp_low_sel;
    logic [5:0]  cmp_high_sel;
    logic [5:0]  ch_wr_low;
    logic [5:0]  ch_wr_high;
    logic [5:0]  ch_lock;
    logic [15:0] count_q;
    logic [7:0]  snap_q;
    logic [95:0] compare_q;
    logic [95:0] reload_q;
    logic [5:0]  cmp_en_q;
    logic [7:0]  cmp_rd_byte;
    logic        cmp_rd_any;

    // every byte of the block lives on one page; other pages see nothing here
    assign page_ok      = (SFR_PAGE == CAD_PAGE);
    assign cnt_low_sel  = page_ok && (SFR_ADDR == CAD_COUNT_LOW);
    assign cnt_high_sel = page_ok && (SFR_ADDR == CAD_COUNT_HIGH);

    // per-module decode, write strobes and the watchdog lock of the last module
    for (genvar i = 0; i < CAD_MODULES; i++) begin : g_mod
        assign cmp_low_sel[i]  = page_ok && (SFR_ADDR == CAD_CMP_LOW_ADDR[i*8 +: 8]);
        assign cmp_high_sel[i] = page_ok && (SFR_ADDR == CAD_CMP_HIGH_ADDR[i*8 +: 8]);
        assign ch_wr_low[i]    = SFR_WR && cmp_low_sel[i];
        assign ch_wr_high[i]   = SFR_WR && cmp_high_sel[i];
        assign ch_lock[i]      = (i == CAD_WD_MODULE) && WATCHDOG_ENABLE;

        cad_channel u_channel (
            .clk         (CLK),
            .reset_n     (RESET_N),
            .wr_low      (ch_wr_low[i]),
            .wr_high     (ch_wr_high[i]),
            .wdata       (SFR_WDATA),
            .reload_sel  (RELOAD_SELECT),
            .mode_lock   (ch_lock[i]),
            .mode_wr     (MODE_WR[i]),
            .mode_cmp_en (MODE_COMPARATOR_ENABLE[i]),
            .compare_q   (compare_q[i*16 +: 16]),
            .reload_q    (reload_q[i*16 +: 16]),
            .cmp_en_q    (cmp_en_q[i])
        );
    end

    // counter and its high-byte snapshot; a low-byte read loads the snapshot
    cad_counter u_counter (
        .clk     (CLK),
        .reset_n (RESET_N),
        .tick    (COUNT_TICK),
        .wr_low  (SFR_WR && cnt_low_sel),
        .wr_high (SFR_WR && cnt_high_sel),
        .rd_low  (SFR_RD && cnt_low_sel),
        .wdata   (SFR_WDATA),
        .wd_lock (WATCHDOG_ENABLE),
        .count_q (count_q),
        .snap_q  (snap_q)
    );

    // module byte readback; the reload select picks compare or reload bytes
    always_comb begin
        cmp_rd_byte = CAD_UNMAPPED_READ;
        cmp_rd_any  = 1'b0;
        for (int k = 0; k < CAD_MODULES; k++) begin
            if (cmp_low_sel[k]) begin
                cmp_rd_any  = 1'b1;
                cmp_rd_byte = RELOAD_SELECT ? reload_q[k*16 +: 8]
                                            : compare_q[k*16 +: 8];
            end
            if (cmp_high_sel[k]) begin
                cmp_rd_any  = 1'b1;
                cmp_rd_byte = RELOAD_SELECT ? reload_q[k*16+8 +: 8]
                                            : compare_q[k*16+8 +: 8];
            end
        end
    end

    // read data is registered: it shows one cycle after the read strobe and holds
    // until the next read; the low read returns the live byte, the high the snapshot
    always_comb begin
        st_nxt = st_r;
        if (SFR_RD) begin
            st_nxt.hit   = cnt_low_sel || cnt_high_sel || cmp_rd_any;
            st_nxt.rdata = CAD_UNMAPPED_READ;
            if (cnt_low_sel) begin
                st_nxt.rdata = count_q[7:0];
            end else if (cnt_high_sel) begin
                st_nxt.rdata = snap_q;
            end else if (cmp_rd_any) begin
                st_nxt.rdata = cmp_rd_byte;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r.rdata <= CAD_RDATA_RST;
            st_r.hit   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SFR_RDATA         = st_r.rdata;
    assign SFR_HIT           = st_r.hit;
    assign COUNTER_VALUE     = count_q;
    assign COMPARE_VALUE     = compare_q;
    assign RELOAD_VALUE      = reload_q;
    assign COMPARATOR_ENABLE = cmp_en_q;

endmodule : cad_counter_array

/* File: cad_core_model.sv */
`timescale 1ns/1ps
module cad_core_model
    import cad_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       hit,
    output logic      [3:0] page,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    // bus idle at time zero
    initial begin
        {page, addr, wdata, wr, rd} = '0;
    end

    // one access; released address and data are inverted so stale values never match
    task automatic op(input logic w, input logic [3:0] p, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic h);
        @(negedge clk);
        {page, addr, wdata, wr, rd} = {p, a, d, w, !w};
        @(negedge clk);
        q = rdata;
        h = hit;
        {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
    endtask : op

    // low byte then high byte back to back gives one coherent sample
    task automatic rd_count(output logic [15:0] v);
        @(negedge clk);
        {page, addr, wr, rd} = {CAD_PAGE, CAD_COUNT_LOW, 2'b01};
        @(negedge clk);
        v[7:0] = rdata;
        addr = CAD_COUNT_HIGH;
        @(negedge clk);
        v[15:8] = rdata;
        {rd, addr} = {1'b0, ~CAD_COUNT_HIGH};
    endtask : rd_count
endmodule : cad_core_model

/* File: cad_counter_array_sva.sv */
`timescale 1ns/1ps
module cad_counter_array_sva
    import cad_pkg::*;
(
    input wire logic        CLK,
    input wire logic        RESET_N,
    input wire logic [3:0]  SFR_PAGE,
    input wire logic [7:0]  SFR_ADDR,
    input wire logic [7:0]  SFR_WDATA,
    input wire logic        SFR_WR,
    input wire logic        SFR_RD,
    input wire logic [7:0]  SFR_RDATA,
    input wire logic        SFR_HIT,
    input wire logic        COUNT_TICK,
    input wire logic        WATCHDOG_ENABLE,
    input wire logic        RELOAD_SELECT,
    input wire logic [15:0] COUNTER_VALUE,
    input wire logic [95:0] COMPARE_VALUE,
    input wire logic [95:0] RELOAD_VALUE,
    input wire logic [5:0]  COMPARATOR_ENABLE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // strobes that decode on page zero only
    wire w0 = SFR_WR && SFR_PAGE == CAD_PAGE;
    wire r0 = SFR_RD && SFR_PAGE == CAD_PAGE;

    AST_CNT_LOW_WR: assert property (w0 && SFR_ADDR == CAD_COUNT_LOW && !WATCHDOG_ENABLE
        |=> COUNTER_VALUE[7:0] == $past(SFR_WDATA)) else $error("counter low write lost");
    AST_LOCK_LOW: assert property (w0 && SFR_ADDR == CAD_COUNT_LOW && WATCHDOG_ENABLE
        && !COUNT_TICK |=> $stable(COUNTER_VALUE)) else $error("locked low byte written");
    AST_LOCK_HIGH: assert property (w0 && SFR_ADDR == CAD_COUNT_HIGH && WATCHDOG_ENABLE
        && !COUNT_TICK |=> $stable(COUNTER_VALUE)) else $error("locked high byte written");
    AST_SNAP: assert property (r0 && SFR_ADDR == CAD_COUNT_LOW ##1 r0 && SFR_ADDR == CAD_COUNT_HIGH
        |=> SFR_RDATA == $past(COUNTER_VALUE[15:8], 2)) else $error("snapshot mismatch");
    AST_CE_CLR: assert property (w0 && SFR_ADDR == CAD_CMP_LOW_ADDR[7:0]
        |=> !COMPARATOR_ENABLE[0]) else $error("enable not cleared");
    AST_CE_SET: assert property (w0 && SFR_ADDR == CAD_CMP_HIGH_ADDR[7:0]
        |=> COMPARATOR_ENABLE[0]) else $error("enable not set");
    AST_RLD_LOW: assert property (w0 && SFR_ADDR == CAD_CMP_LOW_ADDR[7:0] && RELOAD_SELECT
        |=> RELOAD_VALUE[7:0] == $past(SFR_WDATA) && $stable(COMPARE_VALUE[7:0]))
        else $error("reload low write wrong");
    AST_PAGE: assert property (SFR_RD && SFR_PAGE != CAD_PAGE
        |=> !SFR_HIT && SFR_RDATA == CAD_UNMAPPED_READ) else $error("other page decoded");
    AST_WD_CE5: assert property (WATCHDOG_ENABLE |=> $stable(COMPARATOR_ENABLE[5]))
        else $error("module five enable changed");
endmodule : cad_counter_array_sva

bind cad_counter_array cad_counter_array_sva u_sva (.CLK(CLK), .RESET_N(RESET_N),
    .SFR_PAGE(SFR_PAGE), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT), .COUNT_TICK(COUNT_TICK),
    .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .RELOAD_SELECT(RELOAD_SELECT),
    .COUNTER_VALUE(COUNTER_VALUE), .COMPARE_VALUE(COMPARE_VALUE),
    .RELOAD_VALUE(RELOAD_VALUE), .COMPARATOR_ENABLE(COMPARATOR_ENABLE));

/* File: cad_counter_array_test.sv */
`timescale 1ns/1ps
module cad_counter_array_test
    import cad_pkg::*;
;
    logic        clk, reset_n, tick, wd_en, rl_sel, wr, rd, hit, h;
    logic [5:0]  mode_wr, mode_en, ce;
    logic [3:0]  page;
    logic [7:0]  addr, wdata, rdata, q;
    logic [15:0] cnt, v;
    logic [95:0] cmp, rld;
    int          miscompares, compares;

    cad_counter_array dut (.CLK(clk), .RESET_N(reset_n), .SFR_PAGE(page), .SFR_ADDR(addr),
        .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_HIT(hit),
        .COUNT_TICK(tick), .WATCHDOG_ENABLE(wd_en), .RELOAD_SELECT(rl_sel), .MODE_WR(mode_wr),
        .MODE_COMPARATOR_ENABLE(mode_en), .COUNTER_VALUE(cnt), .COMPARE_VALUE(cmp),
        .RELOAD_VALUE(rld), .COMPARATOR_ENABLE(ce));
    cad_core_model core (.clk(clk), .rdata(rdata), .hit(hit), .page(page), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // read and compare hit flag with data in one value
    task automatic rc(input string n, input logic [3:0] p, input logic [7:0] a,
                      input logic [8:0] e);
        core.op(1'b0, p, a, 8'h00, q, h);
        chk(n, {7'h00, e}, {7'h00, h, q});
    endtask : rc

    task automatic wt(input logic [7:0] a, input logic [7:0] d);
        core.op(1'b1, CAD_PAGE, a, d, q, h);
    endtask : wt

    task automatic t_reset;
        for (int i = 0; i < 6; i++) begin
            rc("cmp low", CAD_PAGE, CAD_CMP_LOW_ADDR[8*i+:8], 9'h100);
            rc("cmp high", CAD_PAGE, CAD_CMP_HIGH_ADDR[8*i+:8], 9'h100);
        end
        rc("count low", CAD_PAGE, CAD_COUNT_LOW, 9'h100);
        rc("count high", CAD_PAGE, CAD_COUNT_HIGH, 9'h100);
        rc("unmapped", CAD_PAGE, 8'h80, 9'h000);
    endtask : t_reset

    // the high byte write after the sample must not reach the snapshot
    task automatic t_counter;
        wt(CAD_COUNT_LOW, 8'h34);
        wt(CAD_COUNT_HIGH, 8'h12);
        tick = 1'b1;
        repeat (3) @(negedge clk);
        tick = 1'b0;
        chk("counter", 16'h1237, cnt);
        core.rd_count(v);
        chk("sample", 16'h1237, v);
        wt(CAD_COUNT_HIGH, 8'h56);
        rc("snapshot", CAD_PAGE, CAD_COUNT_HIGH, 9'h112);
    endtask : t_counter

    task automatic t_modules;
        logic [7:0] lv;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 6; i++) begin
                lv = 8'(i * 16 + s);
                rl_sel = s[0];
                wt(CAD_CMP_LOW_ADDR[8*i+:8], lv);
                chk("ce low", 16'h0000, {15'h0000, ce[i]});
                wt(CAD_CMP_HIGH_ADDR[8*i+:8], ~lv);
                chk("ce high", 16'h0001, {15'h0000, ce[i]});
                chk("value", {~lv, lv}, s ? rld[16*i+:16] : cmp[16*i+:16]);
                rc("readback", CAD_PAGE, CAD_CMP_HIGH_ADDR[8*i+:8], {1'b1, ~lv});
                rc("readback low", CAD_PAGE, CAD_CMP_LOW_ADDR[8*i+:8], {1'b1, lv});
            end
        end
        chk("compare kept", 16'hff00, cmp[15:0]);
        core.op(1'b1, 4'h1, CAD_CMP_LOW_ADDR[7:0], 8'hee, q, h);
        chk("page write", 16'h0101, {7'h00, ce[0], rld[7:0]});
        rc("page read", 4'h1, CAD_COUNT_LOW, 9'h000);
    endtask : t_modules

    // watchdog on: counter and module five enable frozen, module five bytes still write
    task automatic t_lock;
        wd_en = 1'b1;
        wt(CAD_COUNT_LOW, 8'haa);
        wt(CAD_COUNT_HIGH, 8'hbb);
        chk("locked counter", 16'h5637, cnt);
        wt(CAD_CMP_LOW_ADDR[47:40], 8'h5a);
        chk("mod5 low", 16'h005a, {8'h00, rld[87:80]});
        mode_wr = 6'h21;
        @(negedge clk);
        mode_wr = 6'h00;
        chk("enables", 16'h003e, {10'h000, ce});
        wd_en = 1'b0;
    endtask : t_lock

    task automatic stop_test;
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // reset for 16 cycles, released on a falling edge
    initial begin
        {tick, wd_en, rl_sel, mode_wr, mode_en} = '0;
        reset_n = 1'b0;
        miscompares = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        t_reset;
        t_counter;
        t_modules;
        t_lock;
        stop_test;
    end

    // hang guard
    initial begin
        #200000;
        miscompares++;
        stop_test;
    end
endmodule : cad_counter_array_test
